// File: hdl/sysctl_pkg.sv
// Package of the system control unit: register addresses, field positions,
// reset values, timing figures and the shared types.
// Assumes an 8-bit special function register bus and a 100 MHz ref_clk.
package sysctl_pkg;

  // ****************************************
  // Clock and timing figures
  // ****************************************
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned POR_HOLD_MS    = 24;
  localparam int unsigned POR_HOLD_CYC   = POR_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned RST_HOLD_CYC   = 16;
  localparam int unsigned SLOW_OSC_HZ    = 32_000;
  localparam int unsigned WDT_BASE_MS    = 50;
  localparam int unsigned WDT_BASE_TICKS = WDT_BASE_MS * SLOW_OSC_HZ / 1000;
  localparam int unsigned PIN_RST_TICKS  = 2;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [7:0] ADDR_POWER_MODE = 8'h87;
  localparam logic [7:0] ADDR_OPTION     = 8'h94;
  localparam logic [7:0] ADDR_SOFT_CMD   = 8'h97;
  localparam logic [7:0] ADDR_CLOCK_CTRL = 8'hD8;
  localparam logic [7:0] ADDR_USB_POWER  = 8'hF5;
  localparam logic [7:0] ADDR_WDT_AUX    = 8'hF8;
  localparam logic [15:0] ADDR_CFG_HIGH2 = 16'h3FFF;

  // ****************************************
  // Field positions, masks and values
  // ****************************************
  localparam logic [7:0] SOFT_RESET_CODE = 8'h56;
  localparam int unsigned PM_IDLE_BIT    = 0;
  localparam int unsigned PM_STOP_BIT    = 1;
  localparam logic [7:0] PM_RW_MASK      = 8'h8C;
  localparam int unsigned OPT_DIRECT_BIT = 6;
  localparam int unsigned OPT_WPS_LSB    = 4;
  localparam logic [7:0] OPT_RW_MASK     = 8'hFC;
  localparam int unsigned USB_PRES_BIT   = 7;
  localparam int unsigned USB_LOST_BIT   = 6;
  localparam int unsigned AUX_KICK_BIT   = 7;
  localparam int unsigned AUX_WRM_LSB    = 5;
  localparam logic [7:0] AUX_RW_MASK     = 8'h6F;
  localparam int unsigned CFG_PINRST_BIT = 6;
  localparam int unsigned CFG_BOR_LSB    = 4;
  localparam int unsigned CFG_STOPREG_BIT = 2;
  localparam logic [1:0] BOR_LOWEST      = 2'b11;
  localparam logic [1:0] WRM_ALL_MODES   = 2'b11;
  localparam logic [1:0] WRM_RUN_ONLY    = 2'b10;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] POWER_MODE_RST  = 8'h00;
  localparam logic [7:0] OPTION_RST      = 8'h00;
  localparam logic [7:0] WDT_AUX_RST     = 8'h00;
  localparam logic [7:0] CLOCK_CTRL_RST  = 8'h03;
  localparam logic [7:0] CFG_BYTE_RST    = 8'h00;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic [1:0] unused;
    logic       slow_osc_stop;
    logic       idle_periph_clock_stop;
    logic       fast_osc_stop;
    logic       fast_clock_select;
    logic [1:0] sysclk_divider;
  } clock_ctrl_t;

  typedef enum logic [3:0] {
    ST_HOLD = 4'b0001,
    ST_RUN  = 4'b0010,
    ST_IDLE = 4'b0100,
    ST_STOP = 4'b1000
  } op_state_t;

endpackage

// File: hdl/low_pulse_filter.sv
// Qualifier that reports a low level held for a number of sample ticks.
// Assumes the level and the tick are synchronous to ref_clk.
`timescale 1ns/1ps
module low_pulse_filter #(
  parameter int unsigned MIN_TICKS = 2
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Sampled level
  input  wire logic sample_tick,
  input  wire logic level_low,
  // Result
  output logic      hit
);

  logic [7:0] cnt_r;
  logic       armed_r;

  // A low level fires once; the pin must go high again before it rearms.
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !level_low) begin
      cnt_r   <= 8'h00;
      armed_r <= 1'b1;
    end else if (sample_tick && armed_r) begin
      if (cnt_r == 8'(MIN_TICKS - 1)) begin
        armed_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end

  assign hit = level_low && sample_tick && armed_r && (cnt_r == 8'(MIN_TICKS - 1));

endmodule

// File: hdl/tick_divider.sv
// System clock tick generator: picks an oscillator tick stream and divides it.
// Assumes both oscillator ticks are one-cycle pulses synchronous to ref_clk.
`timescale 1ns/1ps
module tick_divider (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Oscillator ticks
  input  wire logic       fast_tick,
  input  wire logic       slow_tick,
  // Requested setting
  input  wire logic       src_sel,
  input  wire logic [1:0] div_code,
  // Result
  output logic            sys_tick,
  output logic            src_active
);

  logic       src_r;
  logic [3:0] cnt_r;
  logic       in_tick;
  logic [3:0] reload;

  assign in_tick = src_r ? fast_tick : slow_tick;

  always_comb begin
    case (div_code)
      2'b00:   reload = 4'hF;
      2'b01:   reload = 4'h3;
      2'b10:   reload = 4'h1;
      default: reload = 4'h0;
    endcase
  end

  // A new source or ratio is latched only at the end of a whole output period,
  // so no shortened system clock period can ever appear.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      src_r <= 1'b0;
      cnt_r <= 4'h0;
    end else if (in_tick) begin
      if (cnt_r == 4'h0) begin
        src_r <= src_sel;
        cnt_r <= reload;
      end else begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end

  assign sys_tick   = in_tick && (cnt_r == 4'h0);
  assign src_active = src_r;

endmodule

// File: hdl/reset_power_clock_mode_control.sv
// System control unit: regulator and brown-out control, reset sources,
// watchdog, system clock selection and the Idle and Stop modes.
// Assumes oscillator ticks, pins and the register bus are synchronous to ref_clk.
//
// Functional notes
// - Direct supply bit switches regulator off.
// - Stop-regulator-off bit turns regulator off in Stop.
// - Direct supply plus stop-off forces lowest threshold.
// - Power-on holds 24 ms, then loads configuration.
// - Pin reset low two slow ticks, if enabled.
// - Writing 56h to command port resets.
// - Watchdog counts slow ticks; kick self-clears.
// - Watchdog reset mode gates resets per state.
// - Period select gives 400/200/100/50 ms.
// - Host power change resets; presence bit readable.
// - Power lost flag cleared by zero or power-on.
// - After reset run slow, divide by one.
// - Divider code picks 16, 4, 2, 1.
// - Source change accepted only with fast running.
// - Fast stop change accepted only in Slow.
// - Slow stop bit halts the slow oscillator.
// - Idle halts CPU; optionally gates peripheral clocks.
// - Idle ends on reset or enabled interrupt.
// - Stop halts all clocks but the watchdog.
// - Stop refused while enabled pin is low.
// - Stop ends only on reset or pin wake-up.
`timescale 1ns/1ps
module reset_power_clock_mode_control
  import sysctl_pkg::*;
#(
  parameter int unsigned POR_CYCLES  = POR_HOLD_CYC,
  parameter int unsigned HOLD_CYCLES = RST_HOLD_CYC,
  parameter int unsigned WDT_BASE    = WDT_BASE_TICKS
) (
  // Clock and power-on reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Special function register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic [7:0]      sfr_rdata,
  // Configuration byte from flash
  input  wire logic [7:0] cfg_flash_byte,
  output logic            cfg_load,
  output logic [7:0]      config_high_byte_two,
  // Oscillators
  input  wire logic       fast_rc_tick,
  input  wire logic       slow_rc_tick,
  output logic            fast_osc_run,
  output logic            slow_osc_run,
  // Reset sources
  input  wire logic       ext_reset_n,
  input  wire logic       host_power_in,
  input  wire logic       brownout_trip,
  output logic            core_reset,
  // Wake-up sources
  input  wire logic [2:0] ext_int_pin,
  input  wire logic [2:0] ext_pin_int_enable,
  input  wire logic       irq_wake,
  input  wire logic       pin_wake,
  // Power and clock outputs
  output logic            regulator_on,
  output logic            direct_supply,
  output logic [1:0]      brownout_level_sel,
  output logic            sys_tick,
  output logic            cpu_clk_en,
  output logic            periph_clk_en,
  output logic            fast_mode
);

  // ****************************************
  // Power-on hold and reset sequencing
  // ****************************************
  logic [31:0] por_cnt_r;
  logic        por_done_r;
  logic [7:0]  cfg_r;
  logic [7:0]  hold_cnt_r;
  logic        host_power_r;
  logic        pin_hit;
  logic        soft_hit;
  logic        wdt_hit;
  logic        usb_edge;
  logic        rst_req;
  logic        sys_hold;
  logic        reg_clr;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      por_cnt_r  <= 32'h0000_0000;
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      if (por_cnt_r == POR_CYCLES - 1) begin
        por_done_r <= 1'b1;
      end else begin
        por_cnt_r <= por_cnt_r + 32'h0000_0001;
      end
    end
  end

  assign cfg_load = !por_done_r && rst_n && (por_cnt_r == POR_CYCLES - 1);

  // Only the power-on path reloads the configuration byte.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cfg_r <= CFG_BYTE_RST;
    end else if (cfg_load) begin
      cfg_r <= cfg_flash_byte;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      host_power_r <= 1'b0;
    end else begin
      host_power_r <= host_power_in;
    end
  end

  assign usb_edge = por_done_r && (host_power_r != host_power_in);
  assign soft_hit = sfr_wr && (sfr_addr == ADDR_SOFT_CMD) && (sfr_wdata == SOFT_RESET_CODE);
  assign rst_req  = por_done_r && (pin_hit || soft_hit || wdt_hit || usb_edge || brownout_trip);

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hold_cnt_r <= 8'h00;
    end else if (rst_req) begin
      hold_cnt_r <= 8'(HOLD_CYCLES);
    end else if (hold_cnt_r != 8'h00) begin
      hold_cnt_r <= hold_cnt_r - 8'h01;
    end
  end

  assign sys_hold   = !por_done_r || (hold_cnt_r != 8'h00);
  assign reg_clr    = !rst_n || sys_hold || rst_req;
  assign core_reset = sys_hold;
  assign config_high_byte_two = cfg_r;

  // The pin is qualified on the slow oscillator so short glitches never reset.
  low_pulse_filter #(
    .MIN_TICKS (PIN_RST_TICKS)
  ) u_pin_filter (
    .ref_clk     (ref_clk),
    .rst_n       (rst_n),
    .sample_tick (slow_rc_tick),
    .level_low   (!ext_reset_n && cfg_r[CFG_PINRST_BIT]),
    .hit         (pin_hit)
  );

  // ****************************************
  // Software registers
  // ****************************************
  logic [7:0]  pm_r;
  logic [7:0]  opt_r;
  logic [7:0]  watchdog_aux_control_r;
  clock_ctrl_t clk_r;
  clock_ctrl_t clk_wr;
  clock_ctrl_t clk_nxt;
  logic        lost_r;
  logic        wr_pm;
  logic        wr_clk;
  logic        stop_block;
  op_state_t   st_r;

  assign wr_pm  = sfr_wr && (sfr_addr == ADDR_POWER_MODE);
  assign wr_clk = sfr_wr && (sfr_addr == ADDR_CLOCK_CTRL);
  assign clk_wr = clock_ctrl_t'(sfr_wdata);
  assign stop_block = |(~ext_int_pin & ext_pin_int_enable);

  always_ff @(posedge ref_clk) begin
    if (reg_clr) begin
      pm_r <= POWER_MODE_RST;
    end else if (wr_pm) begin
      pm_r <= sfr_wdata & PM_RW_MASK;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reg_clr) begin
      opt_r <= OPTION_RST;
    end else if (sfr_wr && (sfr_addr == ADDR_OPTION)) begin
      opt_r <= sfr_wdata & OPT_RW_MASK;
    end
  end

  // The kick bit reads back for one cycle and then drops by itself.
  always_ff @(posedge ref_clk) begin
    if (reg_clr) begin
      watchdog_aux_control_r <= WDT_AUX_RST;
    end else if (sfr_wr && (sfr_addr == ADDR_WDT_AUX)) begin
      watchdog_aux_control_r <= (sfr_wdata & AUX_RW_MASK) | (sfr_wdata & 8'h80);
    end else begin
      watchdog_aux_control_r[AUX_KICK_BIT] <= 1'b0;
    end
  end

  // Locked bits keep their value; a write that would stop the fast oscillator
  // while it clocks the system is dropped for both bits.
  always_comb begin
    clk_nxt = clk_wr;
    clk_nxt.unused = 2'b00;
    if (clk_r.fast_clock_select || fast_mode) begin
      clk_nxt.fast_osc_stop = clk_r.fast_osc_stop;
    end
    if (clk_r.fast_osc_stop) begin
      clk_nxt.fast_clock_select = clk_r.fast_clock_select;
    end
    if (clk_nxt.fast_osc_stop && clk_nxt.fast_clock_select) begin
      clk_nxt.fast_osc_stop     = clk_r.fast_osc_stop;
      clk_nxt.fast_clock_select = clk_r.fast_clock_select;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reg_clr) begin
      clk_r <= clock_ctrl_t'(CLOCK_CTRL_RST);
    end else if (wr_clk) begin
      clk_r <= clk_nxt;
    end
  end

  // Hardware set wins over a software write of zero in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      lost_r <= 1'b0;
    end else if (por_done_r && host_power_r && !host_power_in) begin
      lost_r <= 1'b1;
    end else if (sfr_wr && (sfr_addr == ADDR_USB_POWER) && !sfr_wdata[USB_LOST_BIT]) begin
      lost_r <= 1'b0;
    end
  end

  // ****************************************
  // Operating state
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reg_clr) begin
      st_r <= ST_HOLD;
    end else begin
      case (st_r)
        ST_HOLD: st_r <= ST_RUN;
        ST_RUN: begin
          if (wr_pm && sfr_wdata[PM_STOP_BIT] && !stop_block) begin
            st_r <= ST_STOP;
          end else if (wr_pm && sfr_wdata[PM_IDLE_BIT]) begin
            st_r <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (irq_wake || pin_wake) begin
            st_r <= ST_RUN;
          end
        end
        ST_STOP: begin
          if (pin_wake) begin
            st_r <= ST_RUN;
          end
        end
        default: st_r <= ST_HOLD;
      endcase
    end
  end

  // ****************************************
  // Watchdog
  // ****************************************
  logic [15:0] wdt_cnt_r;
  logic [15:0] wdt_limit;
  logic        wdt_active;
  logic        wdt_tick;

  assign wdt_active = (watchdog_aux_control_r[AUX_WRM_LSB +: 2] == WRM_ALL_MODES) ||
                      ((watchdog_aux_control_r[AUX_WRM_LSB +: 2] == WRM_RUN_ONLY) && (st_r == ST_RUN));
  assign wdt_limit  = 16'(WDT_BASE << (2'b11 - opt_r[OPT_WPS_LSB +: 2]));
  assign wdt_tick   = slow_rc_tick && slow_osc_run;

  always_ff @(posedge ref_clk) begin
    if (reg_clr || watchdog_aux_control_r[AUX_KICK_BIT] || !wdt_active) begin
      wdt_cnt_r <= 16'h0000;
    end else if (wdt_tick) begin
      wdt_cnt_r <= wdt_cnt_r + 16'h0001;
    end
  end

  assign wdt_hit = wdt_active && wdt_tick && (wdt_cnt_r == wdt_limit - 16'h0001);

  // ****************************************
  // Clocks, regulator and brown-out level
  // ****************************************
  logic sys_raw;
  logic src_now;

  tick_divider u_divider (
    .ref_clk    (ref_clk),
    .rst_n      (!reg_clr),
    .fast_tick  (fast_rc_tick && fast_osc_run),
    .slow_tick  (slow_rc_tick && slow_osc_run),
    .src_sel    (clk_r.fast_clock_select),
    .div_code   (clk_r.sysclk_divider),
    .sys_tick   (sys_raw),
    .src_active (src_now)
  );

  assign fast_osc_run  = !clk_r.fast_osc_stop && (st_r != ST_STOP);
  // The slow oscillator must stay up in Stop whenever the watchdog may fire.
  assign slow_osc_run  = !clk_r.slow_osc_stop && ((st_r != ST_STOP) || wdt_active);
  assign sys_tick      = sys_raw && (st_r != ST_STOP);
  assign cpu_clk_en    = (st_r == ST_RUN) && sys_tick;
  assign periph_clk_en = sys_tick && !((st_r == ST_IDLE) && clk_r.idle_periph_clock_stop);
  assign fast_mode     = src_now;

  assign direct_supply = opt_r[OPT_DIRECT_BIT];
  assign regulator_on  = !opt_r[OPT_DIRECT_BIT] &&
                         !(cfg_r[CFG_STOPREG_BIT] && (st_r == ST_STOP));
  assign brownout_level_sel = (opt_r[OPT_DIRECT_BIT] && cfg_r[CFG_STOPREG_BIT]) ?
                              BOR_LOWEST : cfg_r[CFG_BOR_LSB +: 2];

  // ****************************************
  // Register read port
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        ADDR_POWER_MODE: sfr_rdata <= pm_r | {6'h00, st_r == ST_STOP, st_r == ST_IDLE};
        ADDR_OPTION:     sfr_rdata <= opt_r;
        ADDR_CLOCK_CTRL: sfr_rdata <= 8'(clk_r);
        ADDR_USB_POWER:  sfr_rdata <= {host_power_in, lost_r, 6'h00};
        ADDR_WDT_AUX:    sfr_rdata <= watchdog_aux_control_r;
        default:         sfr_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  por_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(por_done_r) |-> $past(cfg_load)) else $error("Config not loaded at end of hold.");
  soft_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (por_done_r && soft_hit) |=> core_reset[*2]) else $error("Soft command did not reset.");
  kick_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    watchdog_aux_control_r[AUX_KICK_BIT] |=> !watchdog_aux_control_r[AUX_KICK_BIT] && (wdt_cnt_r == 16'h0000)) else $error("Kick stuck.");
  wdt_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (watchdog_aux_control_r[AUX_WRM_LSB +: 2] == WRM_RUN_ONLY && st_r == ST_IDLE) |-> !wdt_hit) else $error("Watchdog in Idle.");
  stop_refuse_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_r == ST_RUN && !reg_clr && stop_block && wr_pm && sfr_wdata[PM_STOP_BIT]) |=> st_r != ST_STOP)
    else $error("Stop entered with pin low.");
  stop_wake_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_r == ST_STOP && !pin_wake && !reg_clr) |=> st_r == ST_STOP) else $error("Stop left without pin.");
  fast_pair_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(clk_r.fast_osc_stop && clk_r.fast_clock_select)) else $error("Both fast bits set.");
  lost_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (lost_r && !(sfr_wr && sfr_addr == ADDR_USB_POWER)) |=> lost_r) else $error("Lost flag dropped.");
  bor_force_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (direct_supply && cfg_r[CFG_STOPREG_BIT]) |-> (brownout_level_sel == BOR_LOWEST && !regulator_on))
    else $error("Lowest threshold not forced.");
  stop_clock_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (st_r == ST_STOP) |-> !sys_tick && !cpu_clk_en && !fast_osc_run) else $error("Clock runs in Stop.");

endmodule

// File: testbench/reset_power_clock_mode_control_bench.sv
// Self-checking bench of the system control unit, driven through its register port.
// Assumes the package and the design modules are compiled first, and uses short counts.
`timescale 1ns/1ps
module reset_power_clock_mode_control_bench;
  import sysctl_pkg::*;
  // ****************************************
  // Signals and design
  // ****************************************
  logic       ref_clk, rst_n, sfr_wr, sfr_rd, fast_rc_tick, slow_rc_tick;
  logic       ext_reset_n, host_power_in, brownout_trip, irq_wake, pin_wake;
  logic       cfg_load, fast_osc_run, slow_osc_run, core_reset, regulator_on, direct_supply;
  logic       sys_tick, cpu_clk_en, periph_clk_en, fast_mode;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, cfg_flash_byte, config_high_byte_two;
  logic [2:0] ext_int_pin, ext_pin_int_enable, osc_cnt;
  logic [1:0] brownout_level_sel;
  int         err_total, n_checks, cycles, c, p, s, n, k;
  reset_power_clock_mode_control #(.POR_CYCLES(20), .HOLD_CYCLES(4), .WDT_BASE(4)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .cfg_flash_byte(cfg_flash_byte),
    .cfg_load(cfg_load), .config_high_byte_two(config_high_byte_two),
    .fast_rc_tick(fast_rc_tick), .slow_rc_tick(slow_rc_tick), .fast_osc_run(fast_osc_run),
    .slow_osc_run(slow_osc_run), .ext_reset_n(ext_reset_n), .host_power_in(host_power_in),
    .brownout_trip(brownout_trip), .core_reset(core_reset), .ext_int_pin(ext_int_pin),
    .ext_pin_int_enable(ext_pin_int_enable), .irq_wake(irq_wake), .pin_wake(pin_wake),
    .regulator_on(regulator_on), .direct_supply(direct_supply),
    .brownout_level_sel(brownout_level_sel), .sys_tick(sys_tick), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .fast_mode(fast_mode));
  // ****************************************
  // Clock, oscillator ticks and timeout
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // A stopped oscillator gives no ticks, so a wrong stop bit shows up as a stalled clock.
  always @(posedge ref_clk) begin
    osc_cnt <= osc_cnt + 3'h1;
    fast_rc_tick <= fast_osc_run & osc_cnt[0];
    slow_rc_tick <= slow_osc_run & (osc_cnt == 3'h7);
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    @(posedge ref_clk);
    chk(sfr_rdata, exp, "register read");
  endtask
  task automatic expect_reset(input int cyc, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(posedge ref_clk);
      if (core_reset !== 1'b0) seen = (core_reset === 1'b1 && seen !== 1'bx) ? 1'b1 : 1'bx;
    end
    chk({7'h0, seen}, {7'h0, exp}, "reset seen");
  endtask
  task automatic wait_run();
    int i;
    for (i = 0; i < 400 && core_reset !== 1'b0; i++) @(posedge ref_clk);
    chk({7'h0, core_reset}, 8'h00, "reset release");
    @(posedge ref_clk);
  endtask
  task automatic count_en(input int cyc);
    c = 0;
    p = 0;
    s = 0;
    repeat (cyc) begin
      @(posedge ref_clk);
      c += int'(cpu_clk_en === 1'b1);
      p += int'(periph_clk_en === 1'b1);
      s += int'(sys_tick === 1'b1);
    end
  endtask
  task automatic pulse_wake(input logic pin);
    if (pin) pin_wake <= 1'b1;
    else irq_wake <= 1'b1;
    @(posedge ref_clk);
    pin_wake <= 1'b0;
    irq_wake <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic tally_and_finish();
    if (err_total == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rst_n, sfr_wr, sfr_rd, brownout_trip, irq_wake, pin_wake, fast_rc_tick, slow_rc_tick} = '0;
    {sfr_addr, sfr_wdata, osc_cnt, ext_pin_int_enable} = '0;
    {ext_reset_n, host_power_in} = 2'b11;
    ext_int_pin = 3'h7;
    cfg_flash_byte = 8'h54;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    wait_run();
    chk(config_high_byte_two, 8'h54, "config copy");
    chk({6'h0, brownout_level_sel}, 8'h01, "threshold");
    rd(8'hD8, 8'h03);
    rd(8'h94, 8'h00);
    rd(8'h87, 8'h00);
    rd(8'hF8, 8'h00);
    rd(8'hF5, 8'h80);
    rd(8'h90, 8'h00);
    wr(8'h94, 8'h40);
    chk({6'h0, regulator_on, direct_supply}, 8'h01, "direct supply");
    chk({6'h0, brownout_level_sel}, 8'h03, "forced threshold");
    wr(8'h94, 8'h00);
    chk({6'h0, regulator_on, direct_supply}, 8'h02, "regulator");
    // Divide codes 0..3 on the fast source, which ticks every second cycle.
    for (k = 0; k < 4; k++) begin
      wr(8'hD8, 8'h04 | k[7:0]);
      repeat (80) @(posedge ref_clk);
      for (n = 0; n < 100 && sys_tick !== 1'b1; n++) @(posedge ref_clk);
      @(posedge ref_clk);
      for (n = 1; n < 100 && sys_tick !== 1'b1; n++) @(posedge ref_clk);
      chk(8'(n), (k == 0) ? 8'h20 : (k == 1) ? 8'h08 : (k == 2) ? 8'h04 : 8'h02, "period");
    end
    chk({7'h0, fast_mode}, 8'h01, "fast mode");
    wr(8'hD8, 8'h0F);
    rd(8'hD8, 8'h07);
    wr(8'hD8, 8'h03);
    // The divider leaves the fast source only at its next boundary, so wait before stopping it.
    repeat (4) @(posedge ref_clk);
    wr(8'hD8, 8'h0B);
    rd(8'hD8, 8'h0B);
    chk({7'h0, fast_osc_run}, 8'h00, "fast osc");
    wr(8'hD8, 8'h0F);
    rd(8'hD8, 8'h0B);
    wr(8'hD8, 8'h23);
    chk({7'h0, slow_osc_run}, 8'h00, "slow osc");
    wr(8'hD8, 8'h13);
    wr(8'h87, 8'h01);
    count_en(40);
    chk(8'(c + p), 8'h00, "idle gating");
    chk(8'(s > 0), 8'h01, "idle sys clock");
    pulse_wake(1'b0);
    count_en(40);
    chk(8'(c > 0), 8'h01, "idle wake");
    ext_pin_int_enable <= 3'h1;
    ext_int_pin <= 3'h6;
    wr(8'h87, 8'h02);
    rd(8'h87, 8'h00);
    ext_int_pin <= 3'h7;
    wr(8'h87, 8'h02);
    rd(8'h87, 8'h02);
    chk({7'h0, regulator_on}, 8'h00, "stop regulator");
    count_en(40);
    chk(8'(s), 8'h00, "stop clocks");
    pulse_wake(1'b0);
    rd(8'h87, 8'h02);
    pulse_wake(1'b1);
    rd(8'h87, 8'h00);
    chk({7'h0, regulator_on}, 8'h01, "run regulator");
    // Watchdog: 50 ms setting overflows in 32 cycles here, so regular kicks must hold it off.
    wr(8'h94, 8'h30);
    wr(8'hF8, 8'h60);
    for (k = 0; k < 8; k++) begin
      expect_reset(14, 1'b0);
      wr(8'hF8, 8'hE0);
    end
    expect_reset(50, 1'b1);
    wait_run();
    wr(8'h94, 8'h20);
    wr(8'hF8, 8'h60);
    expect_reset(40, 1'b0);
    expect_reset(48, 1'b1);
    wait_run();
    wr(8'h94, 8'h30);
    expect_reset(80, 1'b0);
    wr(8'hF8, 8'h40);
    wr(8'h87, 8'h01);
    expect_reset(80, 1'b0);
    pulse_wake(1'b0);
    expect_reset(50, 1'b1);
    wait_run();
    wr(8'h97, 8'h56);
    expect_reset(8, 1'b1);
    wait_run();
    rd(8'h94, 8'h00);
    chk(config_high_byte_two, 8'h54, "config kept");
    ext_reset_n <= 1'b0;
    @(posedge ref_clk);
    ext_reset_n <= 1'b1;
    expect_reset(30, 1'b0);
    ext_reset_n <= 1'b0;
    expect_reset(40, 1'b1);
    ext_reset_n <= 1'b1;
    wait_run();
    host_power_in <= 1'b0;
    expect_reset(10, 1'b1);
    wait_run();
    rd(8'hF5, 8'h40);
    wr(8'hF5, 8'h00);
    rd(8'hF5, 8'h00);
    brownout_trip <= 1'b1;
    @(posedge ref_clk);
    brownout_trip <= 1'b0;
    expect_reset(10, 1'b1);
    wait_run();
    tally_and_finish();
  end
endmodule
